// File: common/bfs_pkg.sv
// constants and bus carriers for the backlight fault and status register group
package bfs_pkg;

  // =========================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] BFS_IDX_FAULT = 6'h02;
  localparam logic [5:0] BFS_IDX_IDENT = 6'h03;
  localparam logic [5:0] BFS_IDX_FORCE = 6'h04;
  localparam logic [5:0] BFS_IDX_TEMPH = 6'h05;
  localparam logic [5:0] BFS_IDX_TEMPL = 6'h06;

  // =========================================================
  // fault register fields
  localparam int BFS_FB_OPEN  = 7;
  localparam int BFS_FB_SHORT = 6;
  localparam int BFS_FB_MULTI = 5;
  localparam int BFS_FB_ONE   = 4;
  localparam int BFS_FB_ANY   = 3;
  localparam int BFS_FB_OCP   = 2;
  localparam int BFS_FB_TSD   = 1;
  localparam int BFS_FB_UV    = 0;

  // =========================================================
  // reset values and identity defaults (identity values arbitrary)
  localparam logic [7:0] BFS_FAULT_RST = 8'h00;
  localparam logic [7:0] BFS_FORCE_RST = 8'h00;
  localparam logic [2:0] BFS_TEMPL_RST = 3'h0;
  localparam logic       BFS_ID_PANEL  = 1'b0;
  localparam logic [3:0] BFS_ID_MAKER  = 4'h5;
  localparam logic [2:0] BFS_ID_REV    = 3'h1;

  // =========================================================
  // timing and thermal codes (codes are reading values, plain defaults)
  localparam int unsigned BFS_CLK_HZ      = 250_000_000;
  localparam int unsigned BFS_OCP_TIME_MS = 50;
  localparam int unsigned BFS_OCP_CYCLES  = BFS_OCP_TIME_MS * (BFS_CLK_HZ / 1000);
  localparam logic [10:0] BFS_TSD_HOT     = 11'h4b0;
  localparam logic [10:0] BFS_TSD_COOL    = 11'h410;

  // =========================================================
  // classic wishbone carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bfs_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } bfs_wb_rsp_t;

endpackage

// File: logic/bfs_fault_regs.sv
// backlight fault flags, protection actions, identity, force and temperature registers
module bfs_fault_regs #(
  parameter int unsigned CH         = 4,
  parameter int unsigned OCP_CYCLES = bfs_pkg::BFS_OCP_CYCLES
) (
  // clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic                 ce,
  // wishbone slave
  input  wire bfs_pkg::bfs_wb_req_t wb_req,
  output bfs_pkg::bfs_wb_rsp_t      wb_rsp,
  // pins from outside
  input  wire logic                 enable_pin,
  input  wire logic                 supply_input_pin_low,
  input  wire logic                 supply_input_pin_good,
  input  wire logic                 boost_out_low,
  // same-clock status inputs
  input  wire logic [CH-1:0]        led_open,
  input  wire logic [CH-1:0]        led_short,
  input  wire logic [10:0]          temp_reading,
  input  wire logic [CH-1:0]        pwm_dim,
  // fault pin, open drain
  output logic                      fault_pin_out,
  output logic                      fault_pin_oe,
  // power stage controls
  output logic                      boost_enable,
  output logic                      led_enable,
  output logic [CH-1:0]             led_drive,
  // low temperature bits of the latched sample
  output logic [2:0]                temp_low_latched
);
  import bfs_pkg::*;

  // =========================================================
  // parameter checks, refused at elaboration
  if (CH < 1 || CH > 8) begin : g_bad_ch
    $error("bfs_fault_regs: CH must be 1 to 8");
  end
  if (OCP_CYCLES < 1) begin : g_bad_ocp
    $error("bfs_fault_regs: OCP_CYCLES must be at least 1");
  end

  // =========================================================
  // pin synchronisers
  logic       en_s;
  logic       uv_low_s;
  logic       uv_good_s;
  logic       boost_low_s;
  logic [3:0] pins_s;

  // reset levels: enable low, no under-voltage, supply good, boost not low
  bfs_sync #(
    .W   (4),
    .RST (4'h4)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .async_in ({boost_out_low, supply_input_pin_good,
                supply_input_pin_low, enable_pin}),
    .sync_out (pins_s)
  );

  assign en_s        = pins_s[0];
  assign uv_low_s    = pins_s[1];
  assign uv_good_s   = pins_s[2];
  assign boost_low_s = pins_s[3];

  // =========================================================
  // wishbone decode
  logic       ack_q;
  logic       ack_d;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  logic [5:0] idx;
  logic       req;
  logic       take;
  logic       rd_any;
  logic       rd_fault;
  logic       rd_temph;
  logic       wr_force;

  assign idx      = wb_req.adr[7:2];
  assign req      = wb_req.cyc && wb_req.stb;
  assign take     = ce && req && !ack_q;
  assign rd_any   = take && !wb_req.we;
  assign rd_fault = rd_any && idx == BFS_IDX_FAULT;
  assign rd_temph = rd_any && idx == BFS_IDX_TEMPH;
  assign wr_force = take && wb_req.we && wb_req.sel[0] && idx == BFS_IDX_FORCE;

  // =========================================================
  // fault flags
  logic [7:0]    flags_q;
  logic [7:0]    flags_d;
  logic [7:0]    flag_set;
  logic          clear_evt;
  logic [CH-1:0] ch_fault;
  logic [3:0]    ch_count;
  logic          ocp_expired;
  logic          tsd_hold_q;
  logic          tsd_hold_d;
  logic          uv_hold_q;
  logic          uv_hold_d;
  logic          tsd_hot;
  logic          tsd_cool;
  logic          ocp_run;
  logic [3:0]    ch_sum [CH+1];

  // thermal window: flag and hold at the hot code, release only at the cool code
  assign tsd_hot  = temp_reading >= BFS_TSD_HOT;
  assign tsd_cool = temp_reading <= BFS_TSD_COOL;

  always_comb begin
    flag_set               = 8'h00;
    flag_set[BFS_FB_OPEN]  = |led_open;
    flag_set[BFS_FB_SHORT] = |led_short;
    flag_set[BFS_FB_MULTI] = ch_count >= 4'h2;
    flag_set[BFS_FB_ONE]   = ch_count == 4'h1;
    flag_set[BFS_FB_ANY]   = |ch_fault;
    flag_set[BFS_FB_OCP]   = ocp_expired;
    flag_set[BFS_FB_TSD]   = tsd_hot;
    flag_set[BFS_FB_UV]    = uv_low_s;
  end

  assign clear_evt = rd_fault || !en_s;

  always_comb begin
    flags_d = flags_q;
    if (ce) begin
      // flags hold until cleared; a new event wins over the clear
      flags_d = (clear_evt ? 8'h00 : flags_q) | flag_set;
    end
  end

  // flag registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_q <= BFS_FAULT_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // =========================================================
  // protection holds
  always_comb begin
    tsd_hold_d = tsd_hold_q;
    uv_hold_d  = uv_hold_q;
    if (ce) begin
      if (tsd_hot) begin
        tsd_hold_d = 1'b1;
      end else if (tsd_cool) begin
        tsd_hold_d = 1'b0;
      end
      if (uv_low_s) begin
        uv_hold_d = 1'b1;
      end else if (uv_good_s) begin
        uv_hold_d = 1'b0;
      end
    end
  end

  // hold registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tsd_hold_q <= 1'b0;
      uv_hold_q  <= 1'b0;
    end else begin
      tsd_hold_q <= tsd_hold_d;
      uv_hold_q  <= uv_hold_d;
    end
  end

  // timer runs only while the boost is switching and its output sags
  assign ocp_run = boost_low_s && boost_enable;

  bfs_ocp_timer #(
    .COUNT (OCP_CYCLES)
  ) u_ocp (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .run      (ocp_run),
    .expired  (ocp_expired)
  );

  // =========================================================
  // force control and temperature snapshot
  logic [CH-1:0] force_q;
  logic [CH-1:0] force_d;
  logic [2:0]    templ_q;
  logic [2:0]    templ_d;

  always_comb begin
    force_d = force_q;
    templ_d = templ_q;
    if (wr_force) begin
      force_d = wb_req.dat[CH-1:0];
    end
    if (rd_temph) begin
      templ_d = temp_reading[2:0];
    end
  end

  // force and snapshot registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      force_q <= BFS_FORCE_RST[CH-1:0];
      templ_q <= BFS_TEMPL_RST;
    end else begin
      force_q <= force_d;
      templ_q <= templ_d;
    end
  end

  // =========================================================
  // read mux and ack
  always_comb begin
    ack_d  = ack_q;
    rdat_d = rdat_q;
    if (ce) begin
      ack_d = req && !ack_q;
      if (rd_any) begin
        case (idx)
          BFS_IDX_FAULT: rdat_d = flags_q;
          BFS_IDX_IDENT: rdat_d = {BFS_ID_PANEL, BFS_ID_MAKER,
                                   BFS_ID_REV};
          BFS_IDX_FORCE: rdat_d = 8'(force_q);
          BFS_IDX_TEMPH: rdat_d = temp_reading[10:3];
          BFS_IDX_TEMPL: rdat_d = {templ_q, 5'h00};
          default:       rdat_d = 8'h00;
        endcase
      end
    end
  end

  // bus answer registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_q  <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // =========================================================
  // outputs
  assign wb_rsp.ack = ack_q;
  assign wb_rsp.dat = {24'h000000, rdat_q};

  assign fault_pin_out = 1'b0;
  assign fault_pin_oe  = |flags_q;

  // boost restarts as soon as the over-current flag is gone
  assign boost_enable = en_s && !flags_q[BFS_FB_OCP]
                        && !tsd_hold_q && !uv_hold_q;
  assign led_enable   = en_s && !tsd_hold_q && !uv_hold_q;

  assign temp_low_latched = templ_q;

  // per channel: fault detect, running count of faulty channels, output drive
  assign ch_sum[0] = 4'h0;
  assign ch_count  = ch_sum[CH];

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      assign ch_fault[g]   = led_open[g] | led_short[g];
      assign ch_sum[g + 1] = ch_sum[g] + {3'h0, ch_fault[g]};
      assign led_drive[g]  = led_enable && (force_q[g] || pwm_dim[g]);
    end
  endgenerate

endmodule

// File: logic/bfs_ocp_timer.sv
// counts how long the boost output has stayed low without a break
module bfs_ocp_timer #(
  parameter int unsigned COUNT = 1000
) (
  // clock, reset, enable
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic ce,
  // monitor
  input  wire logic run,
  output logic      expired
);

  localparam int CW = $clog2(COUNT + 1);

  if (COUNT < 1) begin : g_bad_count
    $error("bfs_ocp_timer: COUNT must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          exp_q;
  logic          exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (ce) begin
      if (!run) begin
        cnt_d = '0;
        exp_d = 1'b0;
      end else if (cnt_q == CW'(COUNT)) begin
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule

// File: logic/bfs_sync.sv
// two flip-flop synchroniser for a group of pin levels
module bfs_sync #(
  parameter int        W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock, reset, enable
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         ce,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = ce ? async_in : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: test/bfs_fault_regs_asserts.sv
// concurrent checks on the ports of the fault and status register group
module bfs_fault_regs_asserts #(
  parameter int unsigned CH = 4
) (
  // clock, reset, enable
  input wire logic                 core_clk,
  input wire logic                 srst,
  input wire logic                 ce,
  // bus
  input wire bfs_pkg::bfs_wb_req_t wb_req,
  input wire bfs_pkg::bfs_wb_rsp_t wb_rsp,
  // status and outputs
  input wire logic [CH-1:0]        led_short,
  input wire logic [10:0]          temp_reading,
  input wire logic [CH-1:0]        pwm_dim,
  input wire logic                 fault_pin_out,
  input wire logic                 fault_pin_oe,
  input wire logic                 boost_enable,
  input wire logic                 led_enable,
  input wire logic [CH-1:0]        led_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  import bfs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // =========================================================
  // assertions
  ack_one_cycle_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  ack_after_req_a: assert property (wb_req.cyc && wb_req.stb && ce && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not acked next cycle");
  pin_drive_low_a: assert property (fault_pin_out == 1'b0)
    else $error("fault pin driven high");
  short_pulls_pin_a: assert property (ce && |led_short |=> fault_pin_oe)
    else $error("led fault did not pull fault pin");
  hot_stops_power_a: assert property (ce && temp_reading >= BFS_TSD_HOT |-> ##[1:2]
    (!boost_enable && !led_enable)) else $error("hot device kept power on");
  off_leds_dark_a: assert property (!led_enable |-> led_drive == '0)
    else $error("leds driven while disabled");
  pwm_passes_a: assert property (led_enable |-> (led_drive & pwm_dim) == pwm_dim)
    else $error("dimming pwm lost");
  ident_value_a: assert property (wb_rsp.ack && !$past(wb_req.we)
    && $past(wb_req.adr[7:2] == BFS_IDX_IDENT)
    |-> wb_rsp.dat == {24'h0, BFS_ID_PANEL, BFS_ID_MAKER, BFS_ID_REV}) else $error("bad ident");
  temp_high_a: assert property (wb_rsp.ack && !$past(wb_req.we)
    && $past(wb_req.adr[7:2] == BFS_IDX_TEMPH)
    |-> wb_rsp.dat[7:0] == $past(temp_reading[10:3])) else $error("bad temp byte");
  // =========================================================
  // covers
  fault_read_c: cover property (wb_rsp.ack && wb_rsp.dat[BFS_FB_OCP]);
  boost_back_c: cover property (!boost_enable ##1 boost_enable);
  pin_release_c: cover property (fault_pin_oe ##1 !fault_pin_oe);
endmodule

bind bfs_fault_regs bfs_fault_regs_asserts #(.CH(CH)) i_chk (.core_clk, .srst, .ce, .wb_req,
  .wb_rsp, .led_short, .temp_reading, .pwm_dim, .fault_pin_out, .fault_pin_oe, .boost_enable,
  .led_enable, .led_drive);

// File: test/bfs_fault_regs_tb.sv
// self-checking bench for the fault and status register group
module bfs_fault_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bfs_pkg::*;
  logic core_clk = 0, srst = 1, ce = 1, en = 1, uvl = 0, uvg = 1, bl = 0;
  logic [3:0] op = 0, sh = 0, pwm = 0, drv;
  logic [10:0] tmp = 11'h100;
  logic [2:0] tl;
  logic poe, pout, boe, lde;
  bfs_wb_req_t req;
  bfs_wb_rsp_t rsp;
  int err_count = 0, cmp_count = 0, cyc_n = 0;
  bfs_host_model i_host (.core_clk, .wb_req(req), .wb_rsp(rsp));
  bfs_fault_regs #(.CH(4), .OCP_CYCLES(20)) i_dut (.core_clk, .srst, .ce, .wb_req(req),
    .wb_rsp(rsp), .enable_pin(en), .supply_input_pin_low(uvl), .supply_input_pin_good(uvg),
    .boost_out_low(bl), .led_open(op), .led_short(sh), .temp_reading(tmp), .pwm_dim(pwm),
    .fault_pin_out(pout), .fault_pin_oe(poe), .boost_enable(boe), .led_enable(lde),
    .led_drive(drv), .temp_low_latched(tl));
  initial forever #2 core_clk = ~core_clk;
  // =========================================================
  // helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    logic [7:0] q;
    i_host.xfer(1'b0, i, 8'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] q;
    i_host.xfer(1'b1, i, d, q);
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      err_count++;
      final_report;
    end
  end
  // =========================================================
  // tests
  initial begin
    cy(2);
    srst <= 0;
    cy(4);
    rd(BFS_IDX_IDENT, {BFS_ID_PANEL, BFS_ID_MAKER, BFS_ID_REV});
    wr(BFS_IDX_IDENT, 8'hff);
    rd(BFS_IDX_IDENT, {BFS_ID_PANEL, BFS_ID_MAKER, BFS_ID_REV});
    rd(BFS_IDX_FORCE, BFS_FORCE_RST);
    rd(6'h3f, 8'h00);
    wr(BFS_IDX_FAULT, 8'hff);
    rd(BFS_IDX_FAULT, 8'h00);
    tmp <= 11'h2a5;
    rd(BFS_IDX_TEMPH, 8'h54);
    tmp <= 11'h10a;
    rd(BFS_IDX_TEMPL, 8'ha0);
    chk(8'(tl), 8'h05);
    $display("test 1 done");
    wr(BFS_IDX_FORCE, 8'h0a);
    rd(BFS_IDX_FORCE, 8'h0a);
    pwm <= 4'h1;
    cy(1);
    chk(8'(drv), 8'h0b);
    wr(BFS_IDX_FORCE, 8'h00);
    $display("test 2 done");
    sh <= 4'h2;
    cy(1);
    sh <= 0;
    cy(2);
    chk(8'(poe), 8'h01);
    rd(BFS_IDX_FAULT, 8'h58);
    rd(BFS_IDX_FAULT, 8'h00);
    chk(8'(poe), 8'h00);
    op <= 4'h3;
    cy(1);
    op <= 0;
    cy(3);
    rd(BFS_IDX_FAULT, 8'ha8);
    $display("test 3 done");
    uvl <= 1;
    uvg <= 0;
    cy(4);
    chk(8'({boe, lde}), 8'h00);
    uvl <= 0;
    cy(4);
    rd(BFS_IDX_FAULT, 8'h01);
    chk(8'(lde), 8'h00);
    uvg <= 1;
    cy(5);
    chk(8'(lde), 8'h01);
    $display("test 4 done");
    tmp <= BFS_TSD_HOT;
    cy(3);
    chk(8'({boe, lde}), 8'h00);
    tmp <= BFS_TSD_HOT - 11'h1;
    rd(BFS_IDX_FAULT, 8'h02);
    cy(3);
    chk(8'(boe), 8'h00);
    tmp <= BFS_TSD_COOL;
    cy(3);
    chk(8'({boe, lde}), 8'h03);
    tmp <= 11'h100;
    $display("test 5 done");
    bl <= 1;
    cy(12);
    chk(8'(boe), 8'h01);
    cy(20);
    chk(8'(boe), 8'h00);
    bl <= 0;
    cy(4);
    chk(8'({boe, poe}), 8'h01);
    rd(BFS_IDX_FAULT, 8'h04);
    cy(3);
    chk(8'(boe), 8'h01);
    $display("test 6 done");
    sh <= 4'h1;
    cy(1);
    sh <= 0;
    en <= 0;
    cy(5);
    chk(8'({boe, poe}), 8'h00);
    en <= 1;
    cy(5);
    rd(BFS_IDX_FAULT, 8'h00);
    $display("test 7 done");
    ce <= 0;
    sh <= 4'h4;
    cy(2);
    sh <= 0;
    ce <= 1;
    cy(2);
    chk(8'({poe, pout}), 8'h00);
    $display("test 8 done");
    final_report;
  end
endmodule

// File: test/bfs_host_model.sv
// host side wishbone master for the register group
module bfs_host_model (
  // clock
  input  wire logic            core_clk,
  // bus
  output bfs_pkg::bfs_wb_req_t wb_req,
  input  wire bfs_pkg::bfs_wb_rsp_t wb_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import bfs_pkg::*;
  initial wb_req = '0;
  // =========================================================
  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge core_clk);
    wb_req <= {1'b1, 1'b1, w, i, 2'h0, 4'h1, 24'h0, d};
    @(posedge core_clk);
    while (wb_rsp.ack !== 1'b1) @(posedge core_clk);
    q = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask
endmodule
